/* rtl/flash_bus_cycle.sv */
/*
 * One parallel-bus cycle to the flash: a timed write strobe or a timed read.
 * Assumes the caller starts a cycle only while busy is low.
 */
`timescale 1ns/1ps
module flash_bus_cycle (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire logic                                start,
  input  wire flash_ctl_pkg::cyc_t                 cyc,
  output logic                                     busy,
  output logic                                     done,
  output logic [flash_ctl_pkg::DATA_W-1:0]         rd_data,
  output logic [flash_ctl_pkg::ADDR_W-1:0]         flash_addr,
  output logic [flash_ctl_pkg::DATA_W-1:0]         dq_out,
  output logic                                     dq_oe,
  input  wire logic [flash_ctl_pkg::DATA_W-1:0]    dq_in,
  output logic                                     ce_n,
  output logic                                     we_n,
  output logic                                     oe_n
);

  typedef enum logic [3:0] {
    P_IDLE    = 4'b0001,
    P_STROBE  = 4'b0010,
    P_RECOVER = 4'b0100,
    P_READ    = 4'b1000
  } phase_t;

  phase_t     phase_r;
  logic [3:0] cnt_r;

  assign busy = (phase_r != P_IDLE);

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r    <= P_IDLE;
      cnt_r      <= 4'h0;
      done       <= 1'b0;
      rd_data    <= 8'h00;
      flash_addr <= 20'h00000;
      dq_out     <= 8'h00;
      dq_oe      <= 1'b0;
      ce_n       <= 1'b1;
      we_n       <= 1'b1;
      oe_n       <= 1'b1;
    end else begin
      done <= 1'b0;
      case (phase_r)
        P_IDLE: begin
          if (start) begin
            flash_addr <= cyc.addr;
            dq_out     <= cyc.data;
            ce_n       <= 1'b0;
            if (cyc.write) begin
              dq_oe   <= 1'b1;
              we_n    <= 1'b0;
              cnt_r   <= flash_ctl_pkg::WE_LOW_LOAD;
              phase_r <= P_STROBE;
            end else begin
              oe_n    <= 1'b0;
              cnt_r   <= flash_ctl_pkg::READ_LOAD;
              phase_r <= P_READ;
            end
          end
        end
        P_STROBE: begin
          if (cnt_r == 4'h0) begin
            // The flash latches address and data on this rising edge.
            we_n    <= 1'b1;
            cnt_r   <= flash_ctl_pkg::WE_HIGH_LOAD;
            phase_r <= P_RECOVER;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        P_RECOVER: begin
          if (cnt_r == 4'h0) begin
            ce_n    <= 1'b1;
            dq_oe   <= 1'b0;
            done    <= 1'b1;
            phase_r <= P_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        P_READ: begin
          if (cnt_r == 4'h0) begin
            rd_data <= dq_in;
            oe_n    <= 1'b1;
            ce_n    <= 1'b1;
            done    <= 1'b1;
            phase_r <= P_IDLE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        default: begin
          phase_r <= P_IDLE;
        end
      endcase
    end
  end

  a_we_pulse_width: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(we_n) |-> (!we_n && dq_oe)[*2] ##1 we_n)
    else $error("write strobe width wrong");

  a_read_access: assert property (@(posedge core_clk) disable iff (!reset_n)
    $fell(oe_n) |-> ##3 (oe_n && done))
    else $error("read access time wrong");

  a_no_contention: assert property (@(posedge core_clk) disable iff (!reset_n)
    !oe_n |-> !dq_oe)
    else $error("data bus driven during read");

endmodule

/* rtl/flash_ctl_pkg.sv */
/*
 * Constants, command codes, status bit positions, bus timing and carrier
 * types shared by the flash host controller and its bus cycle engine.
 * Assumes a single 25 MHz core clock and a byte-wide parallel flash.
 */
package flash_ctl_pkg;

  // ****************************************************************
  // Widths and command codes
  // ****************************************************************
  localparam int ADDR_W = 20;
  localparam int DATA_W = 8;

  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
  localparam logic [7:0] CMD_PROTECT_SETUP = 8'h60;
  localparam logic [7:0] CMD_SET_BLOCK     = 8'h01;
  localparam logic [7:0] CMD_SET_MASTER    = 8'hF1;
  localparam logic [7:0] CMD_CLEAR_CONFIRM = 8'hD0;
  localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS  = 8'h50;
  localparam logic [7:0] CMD_READ_STATUS   = 8'h70;
  localparam logic [ADDR_W-1:0] ADDR_ZERO  = 20'h00000;

  // ****************************************************************
  // Status register bit positions
  // ****************************************************************
  localparam int READY_BIT       = 7;
  localparam int ERASE_CLEAR_BIT = 5;
  localparam int PROG_SET_BIT    = 4;
  localparam int SUPPLY_BIT      = 3;
  localparam int PROTECT_BIT     = 1;

  // ****************************************************************
  // Bus timing
  // ****************************************************************
  localparam int CLK_MHZ           = 25;
  localparam int T_WE_LOW_NS       = 50;
  localparam int T_WE_HIGH_NS      = 25;
  localparam int T_READ_ACCESS_NS  = 100;
  localparam int WE_LOW_CYC        = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_HIGH_CYC       = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_ACCESS_CYC   = (T_READ_ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] WE_LOW_LOAD  = 4'(WE_LOW_CYC - 1);
  localparam logic [3:0] WE_HIGH_LOAD = 4'(WE_HIGH_CYC - 1);
  localparam logic [3:0] READ_LOAD    = 4'(READ_ACCESS_CYC - 1);

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_PROGRAM      = 3'h0,
    OP_SET_BLOCK    = 3'h1,
    OP_SET_MASTER   = 3'h2,
    OP_CLEAR_BLOCKS = 3'h3,
    OP_CLEAR_STATUS = 3'h4,
    OP_READ_ARRAY   = 3'h5,
    OP_CHECK_STATUS = 3'h6
  } op_t;

  typedef struct packed {
    op_t               op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              defer_check;
    logic              last;
  } req_t;

  typedef struct packed {
    logic supply_err;
    logic protect_err;
    logic sequence_err;
    logic prog_set_err;
    logic erase_clear_err;
  } err_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } cyc_t;

endpackage

/* rtl/flash_program_lock_status_flow.sv */
/*
 * Host controller for a byte-wide flash: byte program, protection set and
 * clear, status polling, error decode, status clear and return to array
 * read. Takes one request at a time from a plain user port list.
 * Assumes the flash sits directly on the generated pins and that the bench
 * resolves the data bus from dq_out and dq_oe.
 */
`timescale 1ns/1ps
module flash_program_lock_status_flow (
  input  wire logic                                core_clk,
  input  wire logic                                reset_n,
  input  wire logic                                req_valid,
  input  wire flash_ctl_pkg::req_t                 req,
  output logic                                     req_ready,
  output logic                                     done,
  output flash_ctl_pkg::err_t                      err,
  output logic [flash_ctl_pkg::DATA_W-1:0]         status,
  output logic [flash_ctl_pkg::ADDR_W-1:0]         flash_addr,
  output logic [flash_ctl_pkg::DATA_W-1:0]         dq_out,
  output logic                                     dq_oe,
  input  wire logic [flash_ctl_pkg::DATA_W-1:0]    dq_in,
  output logic                                     ce_n,
  output logic                                     we_n,
  output logic                                     oe_n,
  output logic                                     reset_powerdown_pin,
  input  wire logic                                ready_busy_output
);

  typedef enum logic [7:0] {
    S_IDLE    = 8'b0000_0001,
    S_SETUP   = 8'b0000_0010,
    S_CONFIRM = 8'b0000_0100,
    S_STATCMD = 8'b0000_1000,
    S_POLL    = 8'b0001_0000,
    S_CLEAR   = 8'b0010_0000,
    S_ARRAY   = 8'b0100_0000,
    S_FINISH  = 8'b1000_0000
  } state_t;

  state_t                            state_r;
  flash_ctl_pkg::req_t               req_r;
  logic                              issued_r;
  logic                              clear_sent_r;
  logic                              array_sent_r;
  flash_ctl_pkg::cyc_t               cyc;
  logic                              cyc_start;
  logic                              cyc_busy;
  logic                              cyc_done;
  logic [flash_ctl_pkg::DATA_W-1:0]  cyc_rd;
  flash_ctl_pkg::err_t               err_nxt;
  logic                              ready_seen;

  // ****************************************************************
  // Bus cycle engine
  // ****************************************************************
  flash_bus_cycle u_cycle (
    .core_clk   (core_clk),
    .reset_n    (reset_n),
    .start      (cyc_start),
    .cyc        (cyc),
    .busy       (cyc_busy),
    .done       (cyc_done),
    .rd_data    (cyc_rd),
    .flash_addr (flash_addr),
    .dq_out     (dq_out),
    .dq_oe      (dq_oe),
    .dq_in      (dq_in),
    .ce_n       (ce_n),
    .we_n       (we_n),
    .oe_n       (oe_n)
  );

  // ****************************************************************
  // Cycle selection
  // ****************************************************************
  always_comb begin
    cyc.write = 1'b1;
    cyc.addr  = req_r.addr;
    cyc.data  = flash_ctl_pkg::CMD_READ_ARRAY;
    case (state_r)
      S_SETUP: begin
        if (req_r.op == flash_ctl_pkg::OP_PROGRAM) begin
          cyc.data = flash_ctl_pkg::CMD_PROGRAM_SETUP;
        end else begin
          cyc.data = flash_ctl_pkg::CMD_PROTECT_SETUP;
        end
        if (req_r.op == flash_ctl_pkg::OP_CLEAR_BLOCKS) begin
          cyc.addr = flash_ctl_pkg::ADDR_ZERO;
        end
      end
      S_CONFIRM: begin
        case (req_r.op)
          flash_ctl_pkg::OP_PROGRAM:    cyc.data = req_r.data;
          flash_ctl_pkg::OP_SET_BLOCK:  cyc.data = flash_ctl_pkg::CMD_SET_BLOCK;
          flash_ctl_pkg::OP_SET_MASTER: cyc.data = flash_ctl_pkg::CMD_SET_MASTER;
          default: begin
            cyc.data = flash_ctl_pkg::CMD_CLEAR_CONFIRM;
            cyc.addr = flash_ctl_pkg::ADDR_ZERO;
          end
        endcase
      end
      S_STATCMD: cyc.data = flash_ctl_pkg::CMD_READ_STATUS;
      S_POLL:    cyc.write = 1'b0;
      S_CLEAR:   cyc.data = flash_ctl_pkg::CMD_CLEAR_STATUS;
      default:   cyc.data = flash_ctl_pkg::CMD_READ_ARRAY;
    endcase
  end

  assign cyc_start = !issued_r && !cyc_busy &&
                     (state_r != S_IDLE) && (state_r != S_FINISH);

  // ****************************************************************
  // Status decode
  // ****************************************************************
  // The error bits are sticky in the flash, so a deferred check still
  // sees every failure of the series since the last status clear.
  always_comb begin
    err_nxt.supply_err      = cyc_rd[flash_ctl_pkg::SUPPLY_BIT];
    err_nxt.protect_err     = cyc_rd[flash_ctl_pkg::PROTECT_BIT];
    err_nxt.sequence_err    = cyc_rd[flash_ctl_pkg::PROG_SET_BIT] &
                              cyc_rd[flash_ctl_pkg::ERASE_CLEAR_BIT];
    err_nxt.prog_set_err    = cyc_rd[flash_ctl_pkg::PROG_SET_BIT] &
                              !cyc_rd[flash_ctl_pkg::ERASE_CLEAR_BIT];
    err_nxt.erase_clear_err = cyc_rd[flash_ctl_pkg::ERASE_CLEAR_BIT] &
                              !cyc_rd[flash_ctl_pkg::PROG_SET_BIT];
  end

  // Polling uses status bit 7; the ready/busy pin is only a hint and is
  // not required because the status read is always available.
  assign ready_seen = cyc_done && cyc_rd[flash_ctl_pkg::READY_BIT];

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r      <= S_IDLE;
      req_r        <= '0;
      issued_r     <= 1'b0;
      clear_sent_r <= 1'b0;
      array_sent_r <= 1'b0;
    end else begin
      if (cyc_start) begin
        issued_r <= 1'b1;
      end else if (cyc_done) begin
        issued_r <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (req_valid) begin
            req_r        <= req;
            clear_sent_r <= 1'b0;
            array_sent_r <= 1'b0;
            if (req.op == flash_ctl_pkg::OP_CLEAR_BLOCKS || req.op == flash_ctl_pkg::OP_READ_ARRAY) begin
              req_r.last <= 1'b1;
            end
            case (req.op)
              flash_ctl_pkg::OP_CLEAR_STATUS: state_r <= S_CLEAR;
              flash_ctl_pkg::OP_READ_ARRAY:   state_r <= S_ARRAY;
              flash_ctl_pkg::OP_CHECK_STATUS: state_r <= S_STATCMD;
              default:                        state_r <= S_SETUP;
            endcase
          end
        end
        S_SETUP: begin
          if (cyc_done) state_r <= S_CONFIRM;
        end
        S_CONFIRM: begin
          if (cyc_done) state_r <= S_POLL;
        end
        S_STATCMD: begin
          if (cyc_done) state_r <= S_POLL;
        end
        S_POLL: begin
          if (ready_seen) begin
            if (!req_r.defer_check && (|err_nxt)) begin
              state_r <= S_CLEAR;
            end else if (req_r.last) begin
              state_r <= S_ARRAY;
            end else begin
              state_r <= S_FINISH;
            end
          end
        end
        S_CLEAR: begin
          if (cyc_done) begin
            clear_sent_r <= 1'b1;
            state_r      <= req_r.last ? S_ARRAY : S_FINISH;
          end
        end
        S_ARRAY: begin
          if (cyc_done) begin
            array_sent_r <= 1'b1;
            state_r      <= S_FINISH;
          end
        end
        S_FINISH: state_r <= S_IDLE;
        default:  state_r <= S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // User-side results
  // ****************************************************************
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_ready <= 1'b0;
      done      <= 1'b0;
      err       <= '0;
      status    <= 8'h00;
    end else begin
      req_ready <= (state_r == S_IDLE) && !req_valid;
      done      <= (state_r == S_FINISH);
      if (state_r == S_IDLE && req_valid) begin
        err <= '0;
      end
      if (state_r == S_POLL && ready_seen) begin
        status <= cyc_rd;
        if (!req_r.defer_check) begin
          err <= err_nxt;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reset_powerdown_pin <= 1'b0;
    end else begin
      reset_powerdown_pin <= 1'b1;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_program_setup: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start && state_r == S_SETUP && req_r.op == flash_ctl_pkg::OP_PROGRAM
    |-> cyc.write && cyc.data == flash_ctl_pkg::CMD_PROGRAM_SETUP)
    else $error("program setup code wrong");

  a_program_same_addr: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start && state_r == S_CONFIRM && req_r.op == flash_ctl_pkg::OP_PROGRAM
    |-> cyc.addr == req_r.addr && cyc.data == req_r.data)
    else $error("program data not at setup address");

  a_protect_setup: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start && state_r == S_SETUP && req_r.op != flash_ctl_pkg::OP_PROGRAM
    |-> cyc.data == flash_ctl_pkg::CMD_PROTECT_SETUP)
    else $error("protection setup code wrong");

  a_confirm_code: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start && state_r == S_CONFIRM && req_r.op == flash_ctl_pkg::OP_SET_MASTER
    |-> cyc.data == flash_ctl_pkg::CMD_SET_MASTER)
    else $error("master set confirm wrong");

  a_clear_confirm: assert property (@(posedge core_clk) disable iff (!reset_n)
    cyc_start && state_r == S_CONFIRM && req_r.op == flash_ctl_pkg::OP_CLEAR_BLOCKS
    |-> cyc.data == flash_ctl_pkg::CMD_CLEAR_CONFIRM)
    else $error("clear confirm code wrong");

  a_poll_gate: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(state_r) == S_POLL && state_r != S_POLL |-> status[flash_ctl_pkg::READY_BIT])
    else $error("left polling before ready");

  a_error_cleared: assert property (@(posedge core_clk) disable iff (!reset_n)
    done && (|err) |-> clear_sent_r)
    else $error("error reported without status clear");

  a_array_return: assert property (@(posedge core_clk) disable iff (!reset_n)
    done && req_r.last |-> array_sent_r)
    else $error("last operation without read array");

  a_defer_check: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_r == S_CLEAR && req_r.op != flash_ctl_pkg::OP_CLEAR_STATUS |-> !req_r.defer_check)
    else $error("status cleared during deferred series");

endmodule

/* verification/flash_dev_model.sv */
/*
 * Pin-level model of the byte-wide flash: command decode, status byte,
 * block and master protection, and knobs for slow or failing operations.
 * Assumes it is the only device on the bus and the host drives all pins.
 */
`timescale 1ns/1ps
module flash_dev_model (
  input  wire logic [19:0] flash_addr,
  input  wire logic [7:0]  dq_out,
  input  wire logic        dq_oe,
  output logic      [7:0]  dq_in,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        reset_powerdown_pin,
  output logic             ready_busy_output
);
  // ****************************************************************
  // State and knobs
  // ****************************************************************
  int          busy_reads  = 0;
  int          fault       = 0;
  logic        supply_bad  = 1'b0;
  int          busy        = 0;
  int          eb;
  logic [7:0]  status_byte = 8'h80;
  logic [7:0]  mode        = 8'hFF;
  logic [7:0]  last_rd     = 8'h00;
  logic [7:0]  mem [0:255];
  logic [15:0] block_lock  = 16'h0000;
  logic        master_lock = 1'b0;

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
  end

  // Protection bits are nonvolatile, so reset leaves them alone.
  always @(posedge we_n or negedge reset_powerdown_pin) begin
    if (!reset_powerdown_pin) begin
      status_byte = 8'h80;
      mode        = 8'hFF;
      busy        = 0;
    end else if (!ce_n && dq_oe) begin
      if (mode == 8'h40 || mode == 8'h60) begin
        busy = busy_reads;
        eb   = (mode == 8'h60 && dq_out == 8'hD0) ? 5 : 4;
        if (fault == 2 || (mode == 8'h60 && !(dq_out inside {8'h01, 8'hF1, 8'hD0}))) begin
          status_byte[5:4] = 2'b11;
        end else if (supply_bad) begin
          status_byte[3]  = 1'b1;
          status_byte[eb] = 1'b1;
        end else if (mode == 8'h40 && block_lock[flash_addr[19:16]]) begin
          status_byte[1] = 1'b1;
        end else if (mode == 8'h60 && dq_out != 8'hF1 && master_lock) begin
          status_byte[1] = 1'b1;
        end else if (fault == 1) begin
          status_byte[eb] = 1'b1;
        end else if (mode == 8'h40) begin
          mem[flash_addr[7:0]] = dq_out;
        end else if (dq_out == 8'h01) begin
          block_lock[flash_addr[19:16]] = 1'b1;
        end else if (dq_out == 8'hF1) begin
          master_lock = 1'b1;
        end else begin
          block_lock = 16'h0000;
        end
        mode = 8'h70;
      end else if (dq_out == 8'h50) begin
        status_byte[6:0] = 7'h00;
      end else begin
        mode = dq_out;
      end
    end
  end

  always @(negedge oe_n) begin
    if (busy > 0) busy--;
  end

  always @(posedge oe_n) last_rd = dq_in;

  assign ready_busy_output = (busy == 0);

  // A released bus shows the inverse of the last byte so stale data never passes.
  always @* begin
    if (ce_n || oe_n) dq_in = ~last_rd;
    else if (mode == 8'hFF) dq_in = mem[flash_addr[7:0]];
    else if (busy > 0) dq_in = 8'h7F;
    else dq_in = status_byte;
  end
endmodule

/* verification/flash_program_lock_status_flow_test.sv */
/*
 * Self-checking bench for the flash host controller: requests on the user
 * port, the flash model on the pins, and a log of every bus write.
 * Assumes one request at a time, issued only after the previous done.
 */
`timescale 1ns/1ps
module flash_program_lock_status_flow_test;
  logic                core_clk;
  logic                reset_n;
  logic                req_valid;
  flash_ctl_pkg::req_t req;
  logic                req_ready;
  logic                done;
  flash_ctl_pkg::err_t err;
  logic [7:0]          status;
  logic [19:0]         flash_addr;
  logic [7:0]          dq_out;
  logic                dq_oe;
  logic [7:0]          dq_in;
  logic                ce_n;
  logic                we_n;
  logic                oe_n;
  logic                reset_powerdown_pin;
  logic                ready_busy_output;
  int                  err_count = 0;
  int                  compares  = 0;
  int                  cycles    = 0;
  logic [7:0]          wd [$];
  logic [19:0]         wa [$];

  flash_program_lock_status_flow DUT (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .done(done), .err(err), .status(status), .flash_addr(flash_addr),
    .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .reset_powerdown_pin(reset_powerdown_pin), .ready_busy_output(ready_busy_output));

  flash_dev_model u_flash (.flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
    .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .reset_powerdown_pin(reset_powerdown_pin),
    .ready_busy_output(ready_busy_output));

  // ****************************************************************
  // Clock, timeout and write log
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      $display("CHECK FAILED run length expected below 6000 seen %0d", cycles);
      end_sim();
    end
  end

  always @(posedge we_n) begin
    if (ce_n === 1'b0) begin
      wd.push_back(dq_out);
      wa.push_back(flash_addr);
    end
  end

  // ****************************************************************
  // Compare and request tasks
  // ****************************************************************
  task automatic chk_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic chk_err(input string name, input flash_ctl_pkg::err_t exp, input flash_ctl_pkg::err_t got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", name, exp, got);
    end
  endtask

  // The write bytes are packed first byte high; err holds until the next request, status until the next completed status poll.
  task automatic step(input flash_ctl_pkg::op_t op, input logic [19:0] a, input logic [7:0] d,
                      input logic df, input logic ls, input logic [31:0] wexp, input int wn,
                      input flash_ctl_pkg::err_t eexp, input logic [7:0] sexp);
    int n;
    wd.delete();
    wa.delete();
    @(posedge core_clk);
    req_valid <= 1'b1;
    req       <= '{op: op, addr: a, data: d, defer_check: df, last: ls};
    @(posedge core_clk);
    req_valid <= 1'b0;
    chk_val("req_ready", 32'h1, {31'h0, req_ready});
    n = 0;
    while (done !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    chk_val("done", 32'h1, {31'h0, done});
    chk_err("err", eexp, err);
    if (sexp !== 8'h00) chk_val("status", {24'h0, sexp}, {24'h0, status});
    chk_val("write count", wn, wd.size());
    for (int i = 0; i < wn; i++) chk_val("write byte", {24'h0, wexp[31-8*i -: 8]}, {24'h0, wd[i]});
    if (op inside {flash_ctl_pkg::OP_PROGRAM, flash_ctl_pkg::OP_SET_BLOCK, flash_ctl_pkg::OP_SET_MASTER}) begin
      chk_val("setup address", {12'h0, a}, {12'h0, wa[0]});
      chk_val("confirm address", {12'h0, a}, {12'h0, wa[1]});
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    reset_n   = 1'b0;
    req_valid = 1'b0;
    req       = '0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    u_flash.busy_reads = 3;
    step(flash_ctl_pkg::OP_PROGRAM, 20'h00012, 8'hA5, 0, 1, 32'h40A5FF00, 3, 5'h00, 8'h80);
    chk_val("array byte", 32'hA5, {24'h0, u_flash.mem[8'h12]});
    u_flash.supply_bad = 1'b1;
    step(flash_ctl_pkg::OP_PROGRAM, 20'h00013, 8'h5A, 1, 0, 32'h405A0000, 2, 5'h00, 8'h00);
    u_flash.supply_bad = 1'b0;
    u_flash.busy_reads = 0;
    step(flash_ctl_pkg::OP_PROGRAM, 20'h00014, 8'hC3, 1, 0, 32'h40C30000, 2, 5'h00, 8'h00);
    step(flash_ctl_pkg::OP_CHECK_STATUS, 20'h00000, 8'h00, 0, 1, 32'h7050FF00, 3, 5'h12, 8'h98);
    step(flash_ctl_pkg::OP_CHECK_STATUS, 20'h00000, 8'h00, 0, 1, 32'h70FF0000, 2, 5'h00, 8'h80);
    u_flash.fault = 2;
    step(flash_ctl_pkg::OP_PROGRAM, 20'h00015, 8'h11, 0, 1, 32'h401150FF, 4, 5'h04, 8'hB0);
    u_flash.fault = 0;
    u_flash.busy_reads = 2;
    step(flash_ctl_pkg::OP_SET_BLOCK, 20'h30000, 8'h00, 1, 0, 32'h60010000, 2, 5'h00, 8'h00);
    step(flash_ctl_pkg::OP_PROGRAM, 20'h30005, 8'h22, 0, 1, 32'h402250FF, 4, 5'h08, 8'h82);
    u_flash.fault = 1;
    step(flash_ctl_pkg::OP_CLEAR_BLOCKS, 20'h00000, 8'h00, 0, 1, 32'h60D050FF, 4, 5'h01, 8'hA0);
    u_flash.fault = 0;
    step(flash_ctl_pkg::OP_CLEAR_BLOCKS, 20'h00000, 8'h00, 0, 1, 32'h60D0FF00, 3, 5'h00, 8'h80);
    step(flash_ctl_pkg::OP_PROGRAM, 20'h30005, 8'h33, 0, 1, 32'h4033FF00, 3, 5'h00, 8'h80);
    step(flash_ctl_pkg::OP_SET_MASTER, 20'h00000, 8'h00, 0, 1, 32'h60F1FF00, 3, 5'h00, 8'h80);
    step(flash_ctl_pkg::OP_CLEAR_BLOCKS, 20'h00000, 8'h00, 0, 1, 32'h60D050FF, 4, 5'h08, 8'h82);
    step(flash_ctl_pkg::OP_CLEAR_BLOCKS, 20'h00000, 8'h00, 1, 1, 32'h60D0FF00, 3, 5'h00, 8'h82);
    step(flash_ctl_pkg::OP_CLEAR_STATUS, 20'h00000, 8'h00, 0, 0, 32'h50000000, 1, 5'h00, 8'h00);
    step(flash_ctl_pkg::OP_CHECK_STATUS, 20'h00000, 8'h00, 0, 1, 32'h70FF0000, 2, 5'h00, 8'h80);
    step(flash_ctl_pkg::OP_READ_ARRAY, 20'h00000, 8'h00, 0, 1, 32'hFF000000, 1, 5'h00, 8'h00);
    end_sim();
  end
endmodule
